// ===== dv/wos_host_model.sv
// Host controller model sampling the drive status outputs
`timescale 1ns/1ps
module wos_host_model (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire wos_pkg::wos_stat_t stat,
	output wos_pkg::wos_stat_t      seen
);
	import wos_pkg::*;
	// ****************
	// Transistor sampling
	// ****************
	// outputs sampled on clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			seen <= '0;
		else
			seen <= stat;
	end
endmodule

// ===== dv/wos_top_bench.sv
// Self-checking testbench for the warning output selector
`timescale 1ns/1ps
module wos_top_bench;
	import wos_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	wos_cond_t   cond;
	wos_stat_t   stat, seen;
	int          n_mismatch, n_compared;
	int          idx  [8] = '{0, 1, 2, 5, 6, 7, 8, 10};
	int          mbit [8] = '{7, 5, 0, 3, 9, 2, 8, 7};
	logic [4:0]  code [8] = '{5'h01, 5'h02, 5'h03, 5'h06,
		5'h07, 5'h08, 5'h09, 5'h16};
	wos_top #(.TICK_MS_CYCLES(4)) i_wos_top (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cond(cond), .stat(stat));
	wos_host_model i_wos_host_model (.pclk(pclk), .presetn(presetn),
		.stat(stat), .seen(seen));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic stat_is(input logic [31:0] exp);
		apb(1'b0, A_STAT, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic trig(input int i, input logic on);
		case (i)
			0: cond.load_pct <= on ? 8'h55 : 8'h00;
			1: cond.regen_pct <= on ? 8'h55 : 8'h00;
			2: cond.battery_mv <= on ? 12'hc80 : 12'hfff;
			5: cond.enc_overheat <= on;
			6: cond.oscillation <= on;
			7: cond.life_short <= on;
			8: cond.scale_alarm <= on;
			default: cond.deterioration <= on;
		endcase
	endtask
	task automatic frame(input logic e);
		@(posedge pclk);
		cond.enc_frame <= 1'b1;
		cond.scale_frame <= 1'b1;
		cond.enc_err <= e;
		cond.scale_err <= e;
		@(posedge pclk);
		cond.enc_frame <= 1'b0;
		cond.scale_frame <= 1'b0;
	endtask
	task automatic final_report;
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ****************
	// Clock and watchdog
	// ****************
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		final_report();
	end
	// ****************
	// Tests
	// ****************
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		cond = '0;
		cond.battery_mv = 12'hfff;
		n_mismatch = 0;
		n_compared = 0;
		repeat (8) @(posedge pclk);
		chk(stat, 0);
		presetn <= 1'b1;
		apb(1'b0, A_SEL, 32'h0000_0000);
		chk(rd, 0);
		apb(1'b0, 8'h1c, 32'h0000_0000);
		chk({31'h0, err}, 1);
		chk(rd, 0);
		{cond.servo_on, cond.pos_cmd, cond.speed_limited} <= 3'h7;
		{cond.alarm_clearable, cond.speed_cmd, cond.speed_mode} <= 3'h7;
		repeat (3) @(posedge pclk);
		chk(seen[4:0], 5'h1f);
		cond.speed_mode <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(seen[4:0], 5'h1d);
		apb(1'b0, A_OUTS, 32'h0000_0000);
		chk(rd, 32'h0000_001d);
		{cond.pos_cmd, cond.speed_limited, cond.alarm_clearable} <= 3'h0;
		cond.speed_cmd <= 1'b0;
		apb(1'b1, A_FEXP, 32'h0000_0002);
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, A_SEL, {27'h0, code[k]});
			apb(1'b1, A_MASK, 32'h1 << mbit[k]);
			trig(idx[k], 1'b1);
			repeat (4) @(posedge pclk);
			trig(idx[k], 1'b0);
			stat_is(0);
			apb(1'b1, A_MASK, 32'h0000_0000);
			trig(idx[k], 1'b1);
			repeat (4) @(posedge pclk);
			trig(idx[k], 1'b0);
			repeat (4) @(posedge pclk);
			stat_is(32'h1 << idx[k]);
			chk(seen[6:5], 2'b11);
			apb(1'b1, A_SEL, {19'h0, code[k], 8'h05});
			repeat (3) @(posedge pclk);
			chk(seen[6:5], 2'b01);
			apb(1'b1, A_SEL, {19'h0, 5'h05, 3'h0, code[k]});
			repeat (3) @(posedge pclk);
			chk(seen[6:5], 2'b10);
			apb(1'b1, A_STAT, 32'h0000_0fff);
			stat_is(0);
		end
		apb(1'b1, A_FEXP, 32'h0000_0000);
		cond.load_pct <= 8'h54;
		cond.regen_pct <= 8'h54;
		cond.battery_mv <= 12'hc81;
		cond.deterioration <= 1'b1;
		repeat (4) @(posedge pclk);
		stat_is(0);
		cond.deterioration <= 1'b0;
		apb(1'b1, A_SEL, 32'h0001_0007);
		trig(6, 1'b1);
		repeat (2) @(posedge pclk);
		trig(6, 1'b0);
		repeat (3900) @(posedge pclk);
		chk(seen[6], 1);
		repeat (400) @(posedge pclk);
		chk(seen[6], 0);
		apb(1'b1, A_LIMIT, 32'h0000_0202);
		apb(1'b0, A_LIMIT, 32'h0000_0000);
		chk(rd, 32'h0000_0202);
		frame(1'b1);
		frame(1'b1);
		stat_is(0);
		frame(1'b1);
		stat_is(32'h0000_0210);
		frame(1'b0);
		apb(1'b1, A_STAT, 32'h0000_0fff);
		apb(1'b1, A_MAINS, 32'h0000_0005);
		cond.mains_off <= 1'b1;
		repeat (60) @(posedge pclk);
		cond.mains_off <= 1'b0;
		stat_is(0);
		apb(1'b1, A_MAINS, 32'h0000_000a);
		cond.mains_off <= 1'b1;
		repeat (60) @(posedge pclk);
		cond.mains_off <= 1'b0;
		stat_is(32'h0000_0800);
		apb(1'b1, A_STAT, 32'h0000_0fff);
		apb(1'b1, A_SEL, 32'h0100_0000);
		cond.servo_on <= 1'b0;
		cond.fan_stopped <= 1'b1;
		repeat (4200) @(posedge pclk);
		stat_is(0);
		cond.servo_on <= 1'b1;
		repeat (4200) @(posedge pclk);
		stat_is(32'h0000_0008);
		cond.fan_stopped <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		chk(stat, 0);
		presetn <= 1'b1;
		stat_is(0);
		chk(seen[0], 1);
		final_report();
	end
endmodule

// ===== include/wos_pkg.sv
// Constants and carrier types for the warning output selector
package wos_pkg;
	// ****************
	// Timing
	// ****************
	localparam int CLK_HZ        = 40_000_000;
	localparam int MS_PER_S      = 1000;
	localparam int TICK_MS_CYC   = CLK_HZ / MS_PER_S;
	localparam int FAN_STOP_S    = 1;
	localparam int FAN_STOP_MS   = FAN_STOP_S * MS_PER_S;
	localparam int LATCH_MIN_S   = 1;
	localparam int LATCH_MAX_S   = 10;
	localparam int MAINS_MIN_MS  = 10;
	localparam int MAINS_MAX_MS  = 1999;
	// ****************
	// Thresholds
	// ****************
	localparam logic [7:0]  LOAD_WARN_PCT = 8'h55;    // 85 %
	localparam logic [11:0] BATT_WARN_MV  = 12'hc80;  // 3200 mV
	// ****************
	// Register map
	// ****************
	localparam logic [7:0] A_SEL    = 8'h00;
	localparam logic [7:0] A_MASK   = 8'h04;
	localparam logic [7:0] A_FEXP   = 8'h08;
	localparam logic [7:0] A_MAINS  = 8'h0c;
	localparam logic [7:0] A_LIMIT  = 8'h10;
	localparam logic [7:0] A_STAT   = 8'h14;
	localparam logic [7:0] A_OUTS   = 8'h18;
	localparam int         FEXP_DET_BIT = 1;
	// ****************
	// Warning table
	// ****************
	localparam int NW    = 12;
	localparam int W_OVL = 0;
	localparam int W_REG = 1;
	localparam int W_BAT = 2;
	localparam int W_FAN = 3;
	localparam int W_ENC = 4;
	localparam int W_EOH = 5;
	localparam int W_OSC = 6;
	localparam int W_LIF = 7;
	localparam int W_SCE = 8;
	localparam int W_SCC = 9;
	localparam int W_DET = 10;
	localparam int W_MPW = 11;
	// Selector code per warning, index 11 down to 0
	localparam logic [NW-1:0][4:0] W_CODE = {5'h0e, 5'h16, 5'h0a, 5'h09,
		5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};
	// Mask bit per warning, index 11 down to 0
	localparam logic [NW-1:0][3:0] W_MBIT = {4'he, 4'h7, 4'ha, 4'h8,
		4'h2, 4'h9, 4'h3, 4'h4, 4'h6, 4'h0, 4'h5, 4'h7};
	// Warnings that never time out
	localparam logic [NW-1:0] W_NOLIM = 12'h084;
	// ****************
	// Carriers
	// ****************
	typedef struct packed {
		logic [7:0]  load_pct;
		logic [7:0]  regen_pct;
		logic [11:0] battery_mv;
		logic        fan_stopped;
		logic        enc_frame;
		logic        enc_err;
		logic        enc_overheat;
		logic        oscillation;
		logic        life_short;
		logic        scale_alarm;
		logic        scale_frame;
		logic        scale_err;
		logic        deterioration;
		logic        mains_off;
		logic        servo_on;
		logic        pos_cmd;
		logic        speed_limited;
		logic        alarm_clearable;
		logic        speed_cmd;
		logic        speed_mode;
	} wos_cond_t;
	typedef struct packed {
		logic warning_out_a;
		logic warning_out_b;
		logic pos_cmd_out;
		logic speed_limit_out;
		logic clearable_alarm_flag;
		logic speed_cmd_out;
		logic servo_on_status;
	} wos_stat_t;
endpackage

// ===== logic/wos_top.sv
// Warning aggregation, latching and status outputs with APB registers
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module wos_top #(
	parameter int unsigned TICK_MS_CYCLES = wos_pkg::TICK_MS_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire wos_pkg::wos_cond_t cond,
	output wos_pkg::wos_stat_t     stat
);
	import wos_pkg::*;

	typedef struct packed {
		logic [4:0]             sel_a;
		logic [4:0]             sel_b;
		logic [3:0]             latch_s;
		logic                   big_frame;
		logic [15:0]            mask;
		logic [15:0]            fexp;
		logic [10:0]            mains_t;
		logic [7:0]             enc_lim;
		logic [7:0]             scl_lim;
		logic [7:0]             enc_cnt;
		logic [7:0]             scl_cnt;
		logic [9:0]             fan_cnt;
		logic [10:0]            mains_cnt;
		logic [15:0]            ms_cnt;
		logic [NW-1:0]          latch;
		logic [NW-1:0][13:0]    ltmr;
		logic [31:0]            rdata;
		wos_stat_t              stat;
	} wos_state_t;

	wos_state_t    st_reg;
	wos_state_t    st_next;
	logic [NW-1:0] raw;
	logic [NW-1:0] det;
	logic          ms_tick;
	logic          fan_hold;
	logic          mapped;
	logic          wr;
	logic          setup;
	logic [13:0]   hold_ms;

	// Selector decode used for both outputs
	function automatic logic sel_out(input logic [4:0] sel,
		input logic [NW-1:0] lat);
		logic r;
		r = 1'b0;
		if (sel == '0)
			r = |lat;
		for (int i = 0; i < NW; i++) begin
			if (sel == W_CODE[i])
				r = r | lat[i];
		end
		return r;
	endfunction

	// Address decode used for the error answer
	function automatic logic is_mapped(input logic [7:0] a);
		return a == A_SEL || a == A_MASK || a == A_FEXP ||
			a == A_MAINS || a == A_LIMIT || a == A_STAT ||
			a == A_OUTS;
	endfunction

	// ****************
	// Bus decode
	// ****************
	assign setup   = psel && !penable;
	assign wr      = psel && penable && pwrite;
	assign mapped  = is_mapped(paddr);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = st_reg.rdata;
	assign stat    = st_reg.stat;
	assign ms_tick = st_reg.ms_cnt == 16'(TICK_MS_CYCLES - 1);
	assign fan_hold = st_reg.big_frame && !cond.servo_on;

	// ****************
	// Raw detection
	// ****************
	always_comb begin
		raw = '0;
		raw[W_OVL] = cond.load_pct >= LOAD_WARN_PCT;
		raw[W_REG] = cond.regen_pct >= LOAD_WARN_PCT;
		raw[W_BAT] = cond.battery_mv <= BATT_WARN_MV;
		raw[W_FAN] = st_reg.fan_cnt >= 10'(FAN_STOP_MS);
		raw[W_ENC] = st_reg.enc_cnt > st_reg.enc_lim;
		raw[W_EOH] = cond.enc_overheat;
		raw[W_OSC] = cond.oscillation;
		raw[W_LIF] = cond.life_short;
		raw[W_SCE] = cond.scale_alarm;
		raw[W_SCC] = st_reg.scl_cnt > st_reg.scl_lim;
		raw[W_DET] = cond.deterioration && st_reg.fexp[FEXP_DET_BIT];
		raw[W_MPW] = st_reg.mains_t >= 11'(MAINS_MIN_MS) &&
			st_reg.mains_t <= 11'(MAINS_MAX_MS) &&
			st_reg.mains_cnt > st_reg.mains_t;
		for (int i = 0; i < NW; i++)
			det[i] = raw[i] && !st_reg.mask[W_MBIT[i]];
	end

	always_comb begin
		if (st_reg.latch_s > 4'(LATCH_MAX_S))
			hold_ms = 14'(LATCH_MAX_S * MS_PER_S);
		else
			hold_ms = 14'(st_reg.latch_s * MS_PER_S);
	end

	// ****************
	// Next state
	// ****************
	always_comb begin
		st_next = st_reg;
		st_next.ms_cnt = ms_tick ? '0 : st_reg.ms_cnt + 16'h0001;
		if (cond.enc_frame) begin
			if (!cond.enc_err)
				st_next.enc_cnt = '0;
			else if (st_reg.enc_cnt != 8'hff)
				st_next.enc_cnt = st_reg.enc_cnt + 8'h01;
		end
		if (cond.scale_frame) begin
			if (!cond.scale_err)
				st_next.scl_cnt = '0;
			else if (st_reg.scl_cnt != 8'hff)
				st_next.scl_cnt = st_reg.scl_cnt + 8'h01;
		end
		if (!cond.fan_stopped || fan_hold)
			st_next.fan_cnt = '0;
		else if (ms_tick && st_reg.fan_cnt < 10'(FAN_STOP_MS))
			st_next.fan_cnt = st_reg.fan_cnt + 10'h001;
		if (!cond.mains_off)
			st_next.mains_cnt = '0;
		else if (ms_tick && st_reg.mains_cnt != 11'h7ff)
			st_next.mains_cnt = st_reg.mains_cnt + 11'h001;
		for (int i = 0; i < NW; i++) begin
			if (wr && paddr == A_STAT && pwdata[i])
				st_next.latch[i] = 1'b0;
			if (det[i]) begin
				st_next.latch[i] = 1'b1;
				st_next.ltmr[i]  = hold_ms;
			end else if (st_reg.latch[i] && !W_NOLIM[i] &&
				st_reg.latch_s != 4'h0) begin
				if (st_reg.ltmr[i] == 14'h0000)
					st_next.latch[i] = 1'b0;
				else if (ms_tick)
					st_next.ltmr[i] = st_reg.ltmr[i] - 14'h0001;
			end
		end
		// Register writes
		if (wr) begin
			unique case (paddr)
				A_SEL: begin
					st_next.sel_a     = pwdata[4:0];
					st_next.sel_b     = pwdata[12:8];
					st_next.latch_s   = pwdata[19:16];
					st_next.big_frame = pwdata[24];
				end
				A_MASK:  st_next.mask    = pwdata[15:0];
				A_FEXP:  st_next.fexp    = pwdata[15:0];
				A_MAINS: st_next.mains_t = pwdata[10:0];
				A_LIMIT: begin
					st_next.enc_lim = pwdata[7:0];
					st_next.scl_lim = pwdata[15:8];
				end
				default: ;
			endcase
		end
		// Read data captured in setup phase
		if (setup && !pwrite) begin
			unique case (paddr)
				A_SEL: st_next.rdata = {7'h00, st_reg.big_frame,
					4'h0, st_reg.latch_s, 3'h0, st_reg.sel_b,
					3'h0, st_reg.sel_a};
				A_MASK:  st_next.rdata = {16'h0000, st_reg.mask};
				A_FEXP:  st_next.rdata = {16'h0000, st_reg.fexp};
				A_MAINS: st_next.rdata = {21'h00_0000, st_reg.mains_t};
				A_LIMIT: st_next.rdata = {16'h0000, st_reg.scl_lim,
					st_reg.enc_lim};
				A_STAT:  st_next.rdata = {20'h0_0000, st_reg.latch};
				A_OUTS:  st_next.rdata = {25'h000_0000, st_reg.stat};
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end
		// selected warning or OR of all
		st_next.stat.warning_out_a = sel_out(st_reg.sel_a, st_reg.latch);
		st_next.stat.warning_out_b = sel_out(st_reg.sel_b, st_reg.latch);
		st_next.stat.pos_cmd_out = cond.pos_cmd;
		st_next.stat.speed_limit_out = cond.speed_limited;
		st_next.stat.clearable_alarm_flag = cond.alarm_clearable;
		st_next.stat.speed_cmd_out = cond.speed_cmd && cond.speed_mode;
		st_next.stat.servo_on_status = cond.servo_on;
	end

	// ****************
	// State register
	// ****************
	// registered outputs, reset off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_servo_status: assert property (
		cond.servo_on |=> stat.servo_on_status)
		else $error("servo status not set");
	a_pos_cmd_out: assert property (
		$rose(cond.pos_cmd) |=> $rose(stat.pos_cmd_out))
		else $error("position command output late");
	a_speed_limit: assert property (
		cond.speed_limited |=> stat.speed_limit_out)
		else $error("speed limit output missing");
	a_clear_alarm: assert property (
		!cond.alarm_clearable |=> !stat.clearable_alarm_flag)
		else $error("clearable flag without cause");
	a_speed_cmd_mode: assert property (
		cond.speed_cmd && !cond.speed_mode |=> !stat.speed_cmd_out)
		else $error("speed command outside speed mode");
	a_overload_det: assert property (
		cond.load_pct >= LOAD_WARN_PCT &&
		!st_reg.mask[W_MBIT[W_OVL]] |=> st_reg.latch[W_OVL])
		else $error("overload not latched");
	a_regen_det: assert property (
		cond.regen_pct >= LOAD_WARN_PCT &&
		!st_reg.mask[W_MBIT[W_REG]] |=> st_reg.latch[W_REG])
		else $error("regeneration not latched");
	a_battery_det: assert property (
		cond.battery_mv <= BATT_WARN_MV &&
		!st_reg.mask[W_MBIT[W_BAT]] |=> st_reg.latch[W_BAT])
		else $error("battery warning not latched");
	a_fan_early: assert property (
		st_reg.fan_cnt < 10'(FAN_STOP_MS) && !st_reg.latch[W_FAN] |=>
		!st_reg.latch[W_FAN])
		else $error("fan warning before stop time");
	a_enc_count: assert property (
		st_reg.enc_cnt > st_reg.enc_lim &&
		!st_reg.mask[W_MBIT[W_ENC]] |=> st_reg.latch[W_ENC])
		else $error("encoder link warning not latched");
	a_eoh_det: assert property (
		cond.enc_overheat && !st_reg.mask[W_MBIT[W_EOH]] |=>
		st_reg.latch[W_EOH])
		else $error("encoder overheat not latched");
	a_osc_det: assert property (
		cond.oscillation && !st_reg.mask[W_MBIT[W_OSC]] |=>
		st_reg.latch[W_OSC])
		else $error("oscillation not latched");
	a_life_det: assert property (
		cond.life_short && !st_reg.mask[W_MBIT[W_LIF]] |=>
		st_reg.latch[W_LIF])
		else $error("lifetime warning not latched");
	a_scale_det: assert property (
		cond.scale_alarm && !st_reg.mask[W_MBIT[W_SCE]] |=>
		st_reg.latch[W_SCE])
		else $error("scale alarm not latched");
	a_scale_count: assert property (
		st_reg.scl_cnt > st_reg.scl_lim &&
		!st_reg.mask[W_MBIT[W_SCC]] |=> st_reg.latch[W_SCC])
		else $error("scale link warning not latched");
	a_mains_window: assert property (
		!st_reg.latch[W_MPW] && (st_reg.mains_t < 11'(MAINS_MIN_MS) ||
		st_reg.mains_t > 11'(MAINS_MAX_MS)) |=> !st_reg.latch[W_MPW])
		else $error("mains warning outside set window");
	a_latch_expire: assert property (
		st_reg.latch[W_OVL] && st_reg.ltmr[W_OVL] == '0 &&
		st_reg.latch_s != '0 && !det[W_OVL] |=> !st_reg.latch[W_OVL])
		else $error("expired warning still latched");
	a_latch_unlim: assert property (
		st_reg.latch[W_OVL] && st_reg.latch_s == '0 &&
		!(wr && paddr == A_STAT) |=> st_reg.latch[W_OVL])
		else $error("unlimited latch dropped");
	a_mask_blocks: assert property (
		st_reg.mask[W_MBIT[W_BAT]] && !st_reg.latch[W_BAT] |=>
		!st_reg.latch[W_BAT])
		else $error("masked battery warning latched");
	a_battery_hold: assert property (
		st_reg.latch[W_BAT] && !(wr && paddr == A_STAT) |=>
		st_reg.latch[W_BAT])
		else $error("battery warning timed out");
	a_det_gated: assert property (
		!st_reg.fexp[FEXP_DET_BIT] && !st_reg.latch[W_DET] |=>
		!st_reg.latch[W_DET])
		else $error("deterioration without enable");
	a_fan_frame: assert property (
		fan_hold |=> st_reg.fan_cnt == '0 ##1
		!$rose(st_reg.latch[W_FAN]))
		else $error("fan counted while idle");
	a_or_select: assert property (
		st_reg.sel_a == '0 && |st_reg.latch |=> stat.warning_out_a)
		else $error("OR selection wrong");
	a_quiet_a: assert property (
		st_reg.latch == '0 |=> !stat.warning_out_a)
		else $error("warning output a without warning");
	a_quiet_b: assert property (
		st_reg.latch == '0 |=> !stat.warning_out_b)
		else $error("warning output b without warning");
	a_pick_b: assert property (
		st_reg.sel_b == W_CODE[W_OSC] && st_reg.latch[W_OSC] |=>
		stat.warning_out_b)
		else $error("selected warning not on output b");
	a_vcmd_on: assert property (
		cond.speed_cmd && cond.speed_mode |=> stat.speed_cmd_out)
		else $error("speed command output missing");
	a_pos_cmd_off: assert property (
		!cond.pos_cmd |=> !stat.pos_cmd_out)
		else $error("position command output without cause");

	c_warn_a: cover property ($rose(stat.warning_out_a));
	c_warn_b: cover property ($rose(stat.warning_out_b));
	c_expire: cover property ($fell(st_reg.latch[W_OVL]));
	c_mains:  cover property ($rose(st_reg.latch[W_MPW]));
	c_fan:    cover property ($rose(st_reg.latch[W_FAN]));
endmodule
